// ===== inc/timer_three_map.vh
`ifndef TIMER_THREE_MAP_VH
`define TIMER_THREE_MAP_VH
// ==================================================
// register addresses on the special-function bus
`define T3_CTRL_ADDR      8'h91
`define T3_RLL_ADDR       8'h92
`define T3_RLH_ADDR       8'h93
`define T3_CNTL_ADDR      8'h94
`define T3_CNTH_ADDR      8'h95
// ==================================================
// control register fields
`define T3_HI_FLAG_BIT    7
`define T3_LO_FLAG_BIT    6
`define T3_LO_IRQ_EN_BIT  5
`define T3_CAP_EN_BIT     4
`define T3_SPLIT_BIT      3
`define T3_RUN_BIT        2
`define T3_ALT_CLK_HI     1
`define T3_ALT_CLK_LO     0
`define T3_CTRL_RESET     8'h00
`define T3_BYTE_RESET     8'h00
// ==================================================
// alternate clock encodings and dividers
`define T3_ALT_SYS12      2'b00
`define T3_ALT_EXT8       2'b01
`define T3_ALT_LFO8       2'b11
`define T3_SYS_DIV        4'd12
`define T3_SLOW_DIV       3'd7
`endif

// ===== logic/slow_clock_sync.v
`timescale 1ns/1ps
`include "timer_three_map.vh"
// ==================================================
// two-flop synchroniser with divide-by-eight and falling-edge detect
module slow_clock_sync (
   ref_clk,
   resetn,
   async_in,
   div8_tick,
   fall_tick
);
   input  wire ref_clk;
   input  wire resetn;
   input  wire async_in;
   output reg  div8_tick;
   output reg  fall_tick;

   reg       meta_q;
   reg       sync_q;
   reg       prev_q;
   reg [2:0] div_q;

   // only sync_q is read beyond the first stage
   always @(posedge ref_clk) begin
      if (!resetn) begin
         meta_q    <= 1'b0;
         sync_q    <= 1'b0;
         prev_q    <= 1'b0;
         div_q     <= 3'd0;
         div8_tick <= 1'b0;
         fall_tick <= 1'b0;
      end else begin
         meta_q    <= async_in;
         sync_q    <= meta_q;
         prev_q    <= sync_q;
         fall_tick <= prev_q & ~sync_q;
         div8_tick <= 1'b0;
         if (sync_q & ~prev_q) begin
            div_q <= div_q + 3'd1;
            if (div_q == `T3_SLOW_DIV)
               div8_tick <= 1'b1;
         end
      end
   end
endmodule // slow_clock_sync

// ===== logic/timer_three_control.v
`timescale 1ns/1ps
`include "timer_three_map.vh"
module timer_three_control (
   ref_clk,
   resetn,
   sfr_addr,
   sfr_wr,
   sfr_wdata,
   sfr_rdata,
   timer_irq_enable,
   high_byte_clock_pick,
   low_byte_clock_pick,
   ext_clk_in,
   low_freq_osc,
   timer_irq_req
);
   input  wire       ref_clk;
   input  wire       resetn;
   input  wire [7:0] sfr_addr;
   input  wire       sfr_wr;
   input  wire [7:0] sfr_wdata;
   output reg  [7:0] sfr_rdata;
   input  wire       timer_irq_enable;
   input  wire       high_byte_clock_pick;
   input  wire       low_byte_clock_pick;
   input  wire       ext_clk_in;
   input  wire       low_freq_osc;
   output reg        timer_irq_req;

   // ==================================================
   // register state
   // count and reload bytes live here, each reached through its own address
   reg       high_overflow_flag_q;
   reg       low_overflow_flag_q;
   reg       low_byte_irq_enable_q;
   reg       lfo_capture_enable_q;
   reg       split_mode_select_q;
   reg       run_control_q;
   reg [1:0] alt_clock_select_q;
   reg [7:0] count_low_byte_q;
   reg [7:0] count_high_byte_q;
   reg [7:0] reload_low_byte_q;
   reg [7:0] reload_high_byte_q;
   reg [3:0] sys_div_q;
   reg       sys12_tick_q;

   wire ext8_tick;
   wire lfo8_tick;
   wire lfo_fall;

   // ==================================================
   // slow sources
   // both slow inputs are asynchronous pins; each passes two flip-flops in the
   // sync module before anything here reads it, so ticks arrive a few system
   // clocks late, and a pin rate near the system clock is lost, not glitched
   // synchronise slow sources
   slow_clock_sync ext_sync (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .async_in  (ext_clk_in),
      .div8_tick (ext8_tick),
      .fall_tick ()
   );

   slow_clock_sync lfo_sync (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .async_in  (low_freq_osc),
      .div8_tick (lfo8_tick),
      .fall_tick (lfo_fall)
   );

   // divide-by-twelve enable from the system clock
   // the divider runs free of the run bit, so the first tick after a start
   // may land anywhere within twelve system clocks
   always @(posedge ref_clk) begin
      if (!resetn) begin
         sys_div_q    <= 4'd0;
         sys12_tick_q <= 1'b0;
      end else begin
         sys12_tick_q <= (sys_div_q == `T3_SYS_DIV - 4'd1);
         if (sys_div_q == `T3_SYS_DIV - 4'd1)
            sys_div_q <= 4'd0;
         else
            sys_div_q <= sys_div_q + 4'd1;
      end
   end

   // ==================================================
   // clock selection
   reg  alt_tick;
   // the reserved code gives no tick at all: a timer parked on it holds its
   // value instead of counting from an undefined source
   // alternate source decode; reserved code never ticks
   always @* begin
      case (alt_clock_select_q)
         `T3_ALT_SYS12: alt_tick = sys12_tick_q;
         `T3_ALT_EXT8:  alt_tick = ext8_tick;
         `T3_ALT_LFO8:  alt_tick = lfo8_tick;
         default:       alt_tick = 1'b0;
      endcase
   end

   // a pick bit of one ignores the alternate field; in 16-bit mode the low
   // byte's pick sets the pace of the whole counter
   // per-byte pick between system clock and alternate
   wire lo_tick = low_byte_clock_pick ? 1'b1 : alt_tick;
   wire hi_tick = high_byte_clock_pick ? 1'b1 : alt_tick;

   // ==================================================
   // counting
   // split bit picks structure
   // run bit gates the whole counter, or the high byte only in split mode
   wire lo_step = split_mode_select_q ? lo_tick : (run_control_q & lo_tick);
   wire hi_step = split_mode_select_q ? (run_control_q & hi_tick) : 1'b0;
   // a wrap is the cycle in which a byte at all ones takes a step; in 16-bit
   // mode only the low byte steps and the high byte follows its carry, so the
   // whole-counter wrap needs both bytes at all ones together
   wire lo_wrap = lo_step & (count_low_byte_q == 8'hff);
   wire w16     = ~split_mode_select_q & lo_wrap & (count_high_byte_q == 8'hff);
   wire hi_wrap = split_mode_select_q ? (hi_step & (count_high_byte_q == 8'hff)) : w16;

   // ==================================================
   // register bus decode
   // one write strobe per mapped address; other addresses are ignored
   wire wr_ctrl = sfr_wr & (sfr_addr == `T3_CTRL_ADDR);
   wire wr_rll  = sfr_wr & (sfr_addr == `T3_RLL_ADDR);
   wire wr_rlh  = sfr_wr & (sfr_addr == `T3_RLH_ADDR);
   wire wr_cntl = sfr_wr & (sfr_addr == `T3_CNTL_ADDR);
   wire wr_cnth = sfr_wr & (sfr_addr == `T3_CNTH_ADDR);
   wire capture = lfo_capture_enable_q & lfo_fall;

   // counter bytes; hardware stepping wins over a same-cycle software write
   // a write in the cycle that the byte steps is dropped, so that a running
   // timer never loses a tick; software should stop the timer before loading it
   always @(posedge ref_clk) begin
      if (!resetn) begin
         count_low_byte_q  <= `T3_BYTE_RESET;
         count_high_byte_q <= `T3_BYTE_RESET;
      end else begin
         if (split_mode_select_q) begin
            // split mode: two separate timers that share only the clock field
            // low byte reloads from its own reload byte
            if (lo_wrap)
               count_low_byte_q <= reload_low_byte_q;
            else if (lo_step)
               count_low_byte_q <= count_low_byte_q + 8'd1;
            else if (wr_cntl)
               count_low_byte_q <= sfr_wdata;
            // high byte reloads from its own reload byte
            if (hi_wrap)
               count_high_byte_q <= reload_high_byte_q;
            else if (hi_step)
               count_high_byte_q <= count_high_byte_q + 8'd1;
            else if (wr_cnth)
               count_high_byte_q <= sfr_wdata;
         end else begin
            // 16-bit mode: the high byte moves only on the low byte's carry
            // full wrap loads the reload pair
            if (w16) begin
               count_low_byte_q  <= reload_low_byte_q;
               count_high_byte_q <= reload_high_byte_q;
            end else if (lo_step) begin
               count_low_byte_q <= count_low_byte_q + 8'd1;
               if (lo_wrap)
                  count_high_byte_q <= count_high_byte_q + 8'd1;
            end else begin
               if (wr_cntl)
                  count_low_byte_q <= sfr_wdata;
               if (wr_cnth)
                  count_high_byte_q <= sfr_wdata;
            end
         end
      end
   end

   // reload bytes, with capture taking the live count
   // capture outranks a write here, since the captured value is the measurement
   // and a stale write landing on top of it would corrupt it silently
   always @(posedge ref_clk) begin
      if (!resetn) begin
         reload_low_byte_q  <= `T3_BYTE_RESET;
         reload_high_byte_q <= `T3_BYTE_RESET;
      end else if (capture) begin
         reload_low_byte_q  <= count_low_byte_q;
         reload_high_byte_q <= count_high_byte_q;
      end else begin
         if (wr_rll)
            reload_low_byte_q <= sfr_wdata;
         if (wr_rlh)
            reload_high_byte_q <= sfr_wdata;
      end
   end

   // ==================================================
   // control register and flags
   // capture mode measures the oscillator, so its edge raises the high flag
   // exactly as an overflow would and shares the same interrupt path
   wire hi_set = hi_wrap | capture;
   reg  high_overflow_flag_d;
   reg  low_overflow_flag_d;

   // a write that clears a flag in the cycle the flag is set again is dropped,
   // so an overflow can never vanish between software reading and clearing it
   // hardware set wins
   always @* begin
      high_overflow_flag_d = high_overflow_flag_q;
      low_overflow_flag_d  = low_overflow_flag_q;
      if (wr_ctrl) begin
         high_overflow_flag_d = sfr_wdata[`T3_HI_FLAG_BIT];
         low_overflow_flag_d  = sfr_wdata[`T3_LO_FLAG_BIT];
      end
      if (hi_set)
         high_overflow_flag_d = 1'b1;
      if (lo_wrap)
         low_overflow_flag_d = 1'b1;
   end

   // fields change only on a control write; flags follow their next value
   always @(posedge ref_clk) begin
      if (!resetn) begin
         high_overflow_flag_q  <= 1'b0;
         low_overflow_flag_q   <= 1'b0;
         low_byte_irq_enable_q <= 1'b0;
         lfo_capture_enable_q  <= 1'b0;
         split_mode_select_q   <= 1'b0;
         run_control_q         <= 1'b0;
         alt_clock_select_q    <= 2'b00;
      end else begin
         if (wr_ctrl) begin
            low_byte_irq_enable_q <= sfr_wdata[`T3_LO_IRQ_EN_BIT];
            lfo_capture_enable_q  <= sfr_wdata[`T3_CAP_EN_BIT];
            split_mode_select_q   <= sfr_wdata[`T3_SPLIT_BIT];
            run_control_q         <= sfr_wdata[`T3_RUN_BIT];
            alt_clock_select_q    <= sfr_wdata[`T3_ALT_CLK_HI:`T3_ALT_CLK_LO];
         end
         high_overflow_flag_q <= high_overflow_flag_d;
         low_overflow_flag_q  <= low_overflow_flag_d;
      end
   end

   // ==================================================
   // interrupt request and read-back
   // the request also looks at this cycle's set, so it rises together with the
   // flag register rather than one cycle behind it; it falls only once software
   // has cleared the flag or the enable is withdrawn
   // high flag request; low flag request; capture sets high flag
   always @(posedge ref_clk) begin
      if (!resetn)
         timer_irq_req <= 1'b0;
      else
         timer_irq_req <= timer_irq_enable &
                          ((high_overflow_flag_q | hi_set) |
                           (low_byte_irq_enable_q & (low_overflow_flag_q | lo_wrap)));
   end

   // control byte as software sees it, flags in the top two bits
   wire [7:0] ctrl_byte = {high_overflow_flag_q, low_overflow_flag_q, low_byte_irq_enable_q,
                           lfo_capture_enable_q, split_mode_select_q, run_control_q,
                           alt_clock_select_q};

   reg [7:0] rd_mux;
   // unmapped addresses read as zero
   always @* begin
      case (sfr_addr)
         `T3_CTRL_ADDR: rd_mux = ctrl_byte;
         `T3_RLL_ADDR:  rd_mux = reload_low_byte_q;
         `T3_RLH_ADDR:  rd_mux = reload_high_byte_q;
         `T3_CNTL_ADDR: rd_mux = count_low_byte_q;
         `T3_CNTH_ADDR: rd_mux = count_high_byte_q;
         default:       rd_mux = 8'h00;
      endcase
   end

   // registering the read data keeps the mux off the bus timing path; the cost
   // is one cycle of latency that the bus master must allow for, and a count
   // read while running shows the value of the cycle the address was presented
   // registered read data, one cycle after the address
   always @(posedge ref_clk) begin
      if (!resetn)
         sfr_rdata <= 8'h00;
      else
         sfr_rdata <= rd_mux;
   end
endmodule // timer_three_control

// ===== verif/timer_three_properties.sv
`timescale 1ns/1ps
// ==================================================
// port checker for the timer control block
module timer_three_props (
   input wire       ref_clk,
   input wire       resetn,
   input wire [7:0] sfr_addr,
   input wire       sfr_wr,
   input wire [7:0] sfr_wdata,
   input wire [7:0] sfr_rdata,
   input wire       timer_irq_enable,
   input wire       timer_irq_req
);
   reg  [7:0] ctl_q;
   wire       c91 = (sfr_addr == 8'h91);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // shadow of the last control write, flags excluded at compare
   always @(posedge ref_clk) if (sfr_wr && c91) ctl_q <= sfr_wdata;
   property p_rst; disable iff (1'b0) !resetn |=> sfr_rdata == 8'h00 && !timer_irq_req; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_unmapped; (sfr_addr < 8'h91 || sfr_addr > 8'h95) |=> sfr_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_readback; sfr_wr && c91 ##1 (c91 && !sfr_wr) |=> sfr_rdata[5:0] == ctl_q[5:0]; endproperty
   a_readback: assert property (p_readback) else $error("control bits lost");
   // flags may only fall through a software write
   property p_hi_sticky; c91 && !sfr_wr && $past(c91) && !$past(sfr_wr) && sfr_rdata[7] |=> sfr_rdata[7]; endproperty
   a_hi_sticky: assert property (p_hi_sticky) else $error("high flag cleared");
   property p_lo_sticky; c91 && !sfr_wr && $past(c91) && !$past(sfr_wr) && sfr_rdata[6] |=> sfr_rdata[6]; endproperty
   a_lo_sticky: assert property (p_lo_sticky) else $error("low flag cleared");
   property p_irq_hi; $past(c91) && !$past(sfr_wr) && !sfr_wr && sfr_rdata[7] && timer_irq_enable
      |-> ##[0:2] (timer_irq_req || !timer_irq_enable); endproperty
   a_irq_hi: assert property (p_irq_hi) else $error("no request on high flag");
   property p_irq_lo; $past(c91) && !$past(sfr_wr) && !sfr_wr && sfr_rdata[6] && sfr_rdata[5] && timer_irq_enable
      |-> ##[0:2] (timer_irq_req || !timer_irq_enable); endproperty
   a_irq_lo: assert property (p_irq_lo) else $error("no request on low flag");
   property p_irq_off; !timer_irq_enable ##1 !timer_irq_enable |-> !timer_irq_req; endproperty
   a_irq_off: assert property (p_irq_off) else $error("request while disabled");
endmodule // timer_three_props
bind timer_three_control timer_three_props i_timer_three_props (.ref_clk, .resetn, .sfr_addr, .sfr_wr,
   .sfr_wdata, .sfr_rdata, .timer_irq_enable, .timer_irq_req);

// ===== verif/testbench.sv
`timescale 1ns/1ps
// ==================================================
// self-checking bench for the timer control block
module testbench;
   reg        ref_clk          = 1'b0;
   reg        resetn           = 1'b0;
   reg  [7:0] sfr_addr         = 8'h00;
   reg        sfr_wr           = 1'b0;
   reg  [7:0] sfr_wdata        = 8'h00;
   reg        timer_irq_enable = 1'b0;
   reg        hi_pick          = 1'b1;
   reg        lo_pick          = 1'b1;
   reg        ext_clk_in       = 1'b0;
   reg        low_freq_osc     = 1'b0;
   wire [7:0] sfr_rdata;
   wire       timer_irq_req;
   integer    bad_count        = 0;
   integer    checks           = 0;
   integer    i;
   reg  [7:0] v;
   timer_three_control i_timer_three_control (.ref_clk, .resetn, .sfr_addr, .sfr_wr, .sfr_wdata,
      .sfr_rdata, .timer_irq_enable, .high_byte_clock_pick(hi_pick), .low_byte_clock_pick(lo_pick),
      .ext_clk_in, .low_freq_osc, .timer_irq_req);
   always #5 ref_clk = ~ref_clk;
   // ==================================================
   // shared tasks
   task test_done; begin
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   end endtask
   task chk(input [8*8:1] name, input [7:0] seen, input [7:0] exp); begin
      checks = checks + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD %0s exp %h seen %h", name, exp, seen);
      end
   end endtask
   // slow sources leave divider phase open, so allow one count either way
   task near(input [8*8:1] name, input [7:0] seen, input [7:0] exp); begin
      chk(name, (seen + 8'h01 >= exp && seen <= exp + 8'h01) ? exp : seen, exp);
   end endtask
   task cyc(input integer n); begin repeat (n) @(posedge ref_clk); end endtask
   task wr(input [7:0] a, input [7:0] d); begin
      @(posedge ref_clk); sfr_addr <= a; sfr_wr <= 1'b1; sfr_wdata <= d;
      @(posedge ref_clk); sfr_wr <= 1'b0;
   end endtask
   // read data is registered one edge after the address
   task rd(input [7:0] a); begin
      @(posedge ref_clk); sfr_addr <= a;
      @(posedge ref_clk); #1 v = sfr_rdata;
   end endtask
   // ==================================================
   // scenarios
   task t_reset; begin
      for (i = 8'h90; i <= 8'h96; i = i + 1) begin rd(i[7:0]); chk("rstval", v, 8'h00); end
   end endtask
   task t_wrap; begin
      @(posedge ref_clk); timer_irq_enable <= 1'b1;
      wr(8'h92, 8'h34); wr(8'h93, 8'h12); wr(8'h94, 8'hfd); wr(8'h95, 8'hff); wr(8'h91, 8'h04);
      cyc(20); rd(8'h91); chk("flags", v & 8'hc0, 8'hc0);
      chk("irq", {7'h0, timer_irq_req}, 8'h01);
      rd(8'h95); chk("reload", v, 8'h12);
      cyc(50); rd(8'h91); chk("sticky", v & 8'hc0, 8'hc0);
      wr(8'h91, 8'h00); cyc(2); #1 chk("irqclr", {7'h0, timer_irq_req}, 8'h00);
   end endtask
   task t_split; begin
      wr(8'h92, 8'h00); wr(8'h93, 8'h80); wr(8'h94, 8'hf0); wr(8'h95, 8'hf0); wr(8'h91, 8'h08);
      cyc(30); rd(8'h95); chk("hstop", v, 8'hf0);
      rd(8'h91); chk("loflag", v, 8'h48);
      chk("noloen", {7'h0, timer_irq_req}, 8'h00);
      wr(8'h91, 8'h68); cyc(3); rd(8'h91); chk("ctl", v, 8'h68);
      chk("loirq", {7'h0, timer_irq_req}, 8'h01);
      wr(8'h91, 8'h6c); cyc(30); rd(8'h95); chk("hreload", v & 8'hf0, 8'h80);
      rd(8'h91); chk("hflag", v & 8'hc0, 8'hc0);
      wr(8'h91, 8'h00);
   end endtask
   task t_clk; begin
      hi_pick <= 1'b0; lo_pick <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h95, 8'h00); wr(8'h94, 8'h00); wr(8'h91, 8'h04 | i[7:0]);
         // each source stays quiet while the other one is selected, so a swapped decode shows
         repeat (48) begin
            cyc(3);
            if (i != 3) ext_clk_in <= ~ext_clk_in;
            if (i != 1) low_freq_osc <= ~low_freq_osc;
         end
         wr(8'h91, 8'h00); rd(8'h94);
         if (i == 2) chk("altclk", v, 8'h00);
         else near("altclk", v, (i == 0) ? 8'h0c : 8'h03);
      end
   end endtask
   task t_cap; begin
      @(posedge ref_clk); hi_pick <= 1'b1; lo_pick <= 1'b1; low_freq_osc <= 1'b1;
      wr(8'h95, 8'h55); wr(8'h94, 8'h00); wr(8'h91, 8'h14);
      cyc(10); low_freq_osc <= 1'b0; cyc(8);
      rd(8'h93); chk("capture", v, 8'h55);
      rd(8'h92); near("caplow", v, 8'h0d);
      chk("capirq", {7'h0, timer_irq_req}, 8'h01);
      wr(8'h91, 8'h00);
   end endtask
   // ==================================================
   // main sequence and watchdog
   initial begin
      cyc(10); resetn <= 1'b1;
      t_reset; t_wrap; t_split; t_clk; t_cap;
      test_done;
   end
   initial begin
      cyc(20000); bad_count = bad_count + 1;
      test_done;
   end
endmodule // testbench
